// File: imsc_pkg.sv
// Package for the interrupt enable set/clear block: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package imsc_pkg;
   localparam int          IMSC_ADDR_W      = 6;
   localparam int          IMSC_DATA_W      = 32;
   localparam int          IMSC_WAIT_N      = 4;
   // Register byte offsets (chosen)
   localparam logic [5:0]  OFS_RAW_FLAGS    = 6'h00;
   localparam logic [5:0]  OFS_MASKED_FLAGS = 6'h04;
   localparam logic [5:0]  OFS_ENABLE_SET   = 6'h08;
   localparam logic [5:0]  OFS_ENABLE_CLEAR = 6'h0C;
   // Field positions
   localparam int          BIT_TIMEOUT      = 0;
   localparam int          BIT_WAIT_LO      = 2;
   localparam int          BIT_WAIT_HI      = 5;
   // Reset values
   localparam logic [5:0]  ENABLE_RESET     = 6'h00;
   localparam logic [5:0]  FLAGS_RESET      = 6'h00;
   // Implemented bits: 5..2 and 0; bit 1 and 31..6 read zero
   localparam logic [5:0]  FLAG_BITS_MASK   = 6'h3D;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// File: imsc_flag_bank.sv
// Sticky event flags with write-one-to-clear and set-wins-over-clear.
// Assumes event pulses and clear strobes are in the aclk domain.
`timescale 1ns/1ps
module imsc_flag_bank #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Events and clears
   input  wire logic [WIDTH-1:0] event_pulse,
   input  wire logic [WIDTH-1:0] clear_strobe,
   // Flags
   output logic      [WIDTH-1:0] flags
);
   import imsc_pkg::*;

   // A new event in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= WIDTH'(FLAGS_RESET);
      end else begin
         flags <= (flags & ~clear_strobe) | event_pulse;
      end
   end
endmodule

// File: imsc_top.sv
// Interrupt enable set/clear logic with raw and masked flags, AXI4-Lite slave.
// Assumes event pulses arrive one cycle wide from controller logic on aclk.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Writing 1 to set bit 0 enables timeout; both registers then read 1.
// [R2] Writing 0 to any enable bit leaves the enable state alone.
// [R3] Timeout enable clears only via 1 written to clear bit 0.
// [R4] Enabled: masked flag follows its event and raises the interrupt.
// [R5] Disabled: masked flag reads 0 and no interrupt comes.
// [R6] Writing 1 to clear bits 5..2 disables that wait-rise interrupt.
// [R7] Wait-rise enable is set only by writing 1 to its set bit.
// [R8] Bits 31..6 and bit 1 read 0; software writes 0 there.
// [R9] Masked timeout flag sets on enabled timeout; writing 1 clears raw too.
// [R10] Set bits 5..2 hold wait-rise enables; writing 1 sets them.
// [R11] Clear bit 0 holds timeout enable; writing 1 disables timeout.
// [R12] One stored enable per source, seen in both; irq is OR of masked.
module imsc_top (
   // Clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // Write address channel
   input  wire logic [imsc_pkg::IMSC_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // Write data channel
   input  wire logic [imsc_pkg::IMSC_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // Write response channel
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // Read address channel
   input  wire logic [imsc_pkg::IMSC_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // Read data channel
   output logic [imsc_pkg::IMSC_DATA_W-1:0] s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Events from the controller
   input  wire logic                        timeout_event,
   input  wire logic [imsc_pkg::IMSC_WAIT_N-1:0] wait_rise_event,
   // Interrupt
   output logic                             irq
);
   import imsc_pkg::*;

   logic [IMSC_ADDR_W-1:0] awaddr_r;
   logic                   aw_held_r;
   logic [IMSC_DATA_W-1:0] wdata_r;
   logic [3:0]             wstrb_r;
   logic                   w_held_r;
   logic                   wr_fire;
   logic                   rd_fire;
   logic [5:0]             enable_r;
   logic [5:0]             raw_flags;
   logic [5:0]             masked_flags;
   logic [5:0]             event_vec;
   logic [5:0]             wr_bits;
   logic [5:0]             set_hit;
   logic [5:0]             clr_hit;
   logic [5:0]             flag_clear;
   logic [IMSC_DATA_W-1:0] rd_value;

   // Word-aligned offset of an address
   function automatic logic [5:0] word_ofs(input logic [IMSC_ADDR_W-1:0] a);
      return {a[5:2], 2'b00};
   endfunction

   // Each channel takes one transfer and holds it until the write fires; neither is taken while bvalid is high
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

   // Write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (word_ofs(awaddr_r) > OFS_ENABLE_CLEAR) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only byte lane 0 carries implemented bits; reserved bits are dropped
   assign wr_bits = wstrb_r[0] ? (wdata_r[5:0] & FLAG_BITS_MASK) : 6'h00;
   assign set_hit = (wr_fire && word_ofs(awaddr_r) == OFS_ENABLE_SET) ? wr_bits : 6'h00;
   assign clr_hit = (wr_fire && word_ofs(awaddr_r) == OFS_ENABLE_CLEAR) ? wr_bits : 6'h00;

   // Single enable store shared by set and clear views
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= ENABLE_RESET;
      end else begin
         // Zeros in set_hit/clr_hit change nothing; set wins a same-cycle tie
         enable_r <= (enable_r & ~clr_hit) | set_hit; // [R1] [R2] [R3] [R6] [R7] [R10] [R11] [R12]
      end
   end

   // Event vector in register layout
   always_comb begin
      event_vec                           = 6'h00;
      event_vec[BIT_TIMEOUT]              = timeout_event;
      event_vec[BIT_WAIT_HI:BIT_WAIT_LO]  = wait_rise_event;
   end

   // Writing 1 to a masked or raw flag clears the raw flag beneath it
   assign flag_clear = (wr_fire && (word_ofs(awaddr_r) == OFS_MASKED_FLAGS ||
                        word_ofs(awaddr_r) == OFS_RAW_FLAGS)) ? wr_bits : 6'h00; // [R9]

   imsc_flag_bank #(
      .WIDTH        (6)
   ) u_raw_flags (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .event_pulse  (event_vec),
      .clear_strobe (flag_clear),
      .flags        (raw_flags)
   );

   // Masked view gated by the enables
   assign masked_flags = raw_flags & enable_r; // [R4] [R5] [R9]
   assign irq          = |masked_flags;        // [R4] [R5] [R12]

   // Read path: one read at a time, answered the cycle after arvalid is taken
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   // Read multiplexer; bits 31..6 and bit 1 are always zero
   always_comb begin
      rd_value = '0;
      unique case (word_ofs(s_axi_araddr))
         OFS_RAW_FLAGS:    rd_value[5:0] = raw_flags;
         OFS_MASKED_FLAGS: rd_value[5:0] = masked_flags;
         OFS_ENABLE_SET:   rd_value[5:0] = enable_r; // [R8] [R12]
         OFS_ENABLE_CLEAR: rd_value[5:0] = enable_r; // [R8] [R12]
         default:          rd_value      = '0;
      endcase
   end

   // Read data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= (word_ofs(s_axi_araddr) > OFS_ENABLE_CLEAR) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: imsc_checker_assertions.sv
// Checker for imsc_top: bus answer timing, zero bits, irq causes.
// Assumes one aclk domain with synchronous active-low reset.
`timescale 1ns/1ps
module imsc_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [5:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Events and interrupt
   input wire logic        timeout_event,
   input wire logic [3:0]  wait_rise_event,
   input wire logic        irq
);
   import imsc_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Both write halves taken at one edge
   sequence s_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_wr; s_both |-> ##[1:2] s_axi_bvalid; endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_rerr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'h3
         |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
   property p_zero; s_axi_rvalid |-> s_axi_rdata[31:6] == 0 && !s_axi_rdata[1]; endproperty
   a_zero: assert property (p_zero) else $error("reserved read bits set");
   property p_bend; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bend: assert property (p_bend) else $error("write answer stuck");
   property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rend: assert property (p_rend) else $error("read answer stuck");
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_busy: assert property (p_busy) else $error("write taken while answering");
   // An interrupt only appears after an event or an enabling write
   property p_irq;
      $rose(irq) |-> $past(timeout_event || (|wait_rise_event)) || s_axi_bvalid;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind imsc_top imsc_checker u_chk (.*);

// File: tb_imsc_top.sv
// Self-checking bench for imsc_top over AXI4-Lite with event pulses.
// Assumes the bench alone drives every block input.
`timescale 1ns/1ps
module tb_imsc_top;
   import imsc_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, timeout_event = 0;
   logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hF, wait_rise_event = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, s_axi_wdata = 0, en;
   logic [33:0] q[$];
   int n_errors = 0, checked = 0;
   imsc_top DUT (.*);
   always #5 aclk = ~aclk;
   task automatic cmp(input string s, input logic [33:0] e, input logic [33:0] g);
      checked++;
      if (e !== g) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Handshakes are judged at the falling edge, released after the next rise
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      logic ta, tw, tb;
      q.push_back({r, 32'h0});
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end while (!tb);
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
      logic ta, tb;
      q.push_back({r, e});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 0;
      end while (!tb);
      s_axi_rready <= 0;
   endtask
   // One-cycle event pulse, then the interrupt level
   task automatic ev(input logic t, input logic [3:0] w, input logic e);
      @(posedge aclk);
      timeout_event <= t;
      wait_rise_event <= w;
      @(posedge aclk);
      timeout_event <= 0;
      wait_rise_event <= 0;
      @(negedge aclk);
      cmp("irq", {33'h0, e}, {33'h0, irq});
   endtask
   // Oldest note against each answer
   always @(negedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) cmp("bresp", q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) cmp("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end
   initial begin
      void'($urandom(11));
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rd(OFS_ENABLE_SET, 0);
      wr(OFS_ENABLE_SET, 1);
      rd(OFS_ENABLE_CLEAR, 1);
      en = ($urandom & 32'h3C) | 32'h1;
      wr(OFS_ENABLE_SET, en);
      wr(OFS_ENABLE_CLEAR, 0);
      wr(OFS_ENABLE_SET, 0);
      rd(OFS_ENABLE_CLEAR, en);
      wr(OFS_ENABLE_CLEAR, en & 32'h3C);
      rd(OFS_ENABLE_SET, 1);
      ev(1, 0, 1);
      rd(OFS_MASKED_FLAGS, 1);
      wr(OFS_MASKED_FLAGS, 1);
      rd(OFS_RAW_FLAGS, 0);
      wr(OFS_ENABLE_CLEAR, 1);
      ev(1, 0, 0);
      rd(OFS_MASKED_FLAGS, 0);
      rd(OFS_RAW_FLAGS, 1);
      wr(OFS_RAW_FLAGS, 1);
      wr(OFS_ENABLE_SET, 32'h3C);
      for (int n = 0; n < 4; n++) begin
         ev(0, 4'h1 << n, 1);
         rd(OFS_MASKED_FLAGS, 32'h4 << n);
         wr(OFS_MASKED_FLAGS, 32'h4 << n);
      end
      rd(6'h10, 0, RESP_SLVERR);
      wr(6'h10, 1, RESP_SLVERR);
      rd(OFS_ENABLE_CLEAR, 32'h3C);
      stop_test;
   end
endmodule
